// file: src/dspm_input_stage.sv
// Multiplier input stage: operand registers, shift chain, multipliers, pipeline
`timescale 1ns/100ps
// ------------------------------------------------------------------
// Operation
// - One arrangement at a time: eight 9x9, four 18x18 or one 36x36.
// - Matched fixed signs give a full 36x36 product.
// - Mixed fixed signs accept 35-bit unsigned by 36-bit signed, either way.
// - Dynamic sign on one side: 36 bits fixed-signed, 35 bits on the other.
// - Two dynamic signs give 35x35; one shared sign gives 36x36.
// - Products leave directly, ready for an in-block adder or accumulator.
// - Each slice has input registers, multiplier and a pipeline register.
// - Optional operand registers load in parallel from fabric routing.
// - Each operand register set picks clock enable and clear from four sets.
// - Shift configuration still feeds the multiplier and drives chain outputs.
// - Chain outputs feed the next slice, and the next block at the end.
// - The chain ends at any slice; total length up to 224 registers.
// - Shift input only in small and medium arrangements, never in large.
// - Either operand may load in parallel while the other shifts.
// - Sign inputs may be unregistered or registered once.
// - Product is signed when either operand is signed.
// - Products are full precision, sum of operand widths.
// ------------------------------------------------------------------
module dspm_input_stage
  import dspm_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 rstn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [OPBUS_W-1:0]   data_a,
  input  wire logic [OPBUS_W-1:0]   data_b,
  input  wire logic                 sign_a,
  input  wire logic                 sign_b,
  input  wire logic [3:0]           ena_set,
  input  wire logic [3:0]           aclr_set,
  input  wire logic [MED_W-1:0]     chain_in_operand_a,
  input  wire logic [MED_W-1:0]     chain_in_operand_b,
  output logic      [MED_W-1:0]     chain_out_operand_a,
  output logic      [MED_W-1:0]     chain_out_operand_b,
  output logic      [PROD_W-1:0]    product,
  output logic                      product_signed
);

  // ----------------------------------------------------------------
  // Arithmetic helpers
  // ----------------------------------------------------------------
  // Extend a w-bit field to 37 bits, sign-filled only when signed.
  // One spare bit lets a 36-bit unsigned operand ride a signed multiply.
  function automatic logic [EXT_W-1:0] dspm_ext(input logic [LARGE_W-1:0] v,
                                                input int w, input logic s);
    logic [EXT_W-1:0] r;
    r = '0;
    for (int i = 0; i < EXT_W; i++) begin
      r[i] = (i < w) ? v[i] : (s & v[w-1]);
    end
    return r;
  endfunction : dspm_ext

  function automatic logic [LARGE_P_W-1:0] dspm_mul(input logic [EXT_W-1:0] a,
                                                    input logic [EXT_W-1:0] b);
    logic signed [2*EXT_W-1:0] p;
    p = $signed(a) * $signed(b);
    return p[LARGE_P_W-1:0];
  endfunction : dspm_mul

  // ----------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0]   ctrl;
  logic [OPC_W-1:0]    opcfg;
  logic [SETSEL_W-1:0] setsel;
  logic                wr_acc;
  logic                rd_setup;
  logic                mapped;
  dspm_mode_e          mode;

  assign pready   = 1'b1;
  assign wr_acc   = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;
  assign mapped   = (paddr == OFF_CTRL) || (paddr == OFF_OPCFG) ||
                    (paddr == OFF_SETSEL) || (paddr == OFF_STATUS);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl   <= CTRL_RST;
      opcfg  <= OPC_RST;
      setsel <= SETSEL_RST;
    end else if (wr_acc) begin
      if (paddr == OFF_CTRL) begin
        ctrl <= pwdata[CTRL_W-1:0];
      end
      if (paddr == OFF_OPCFG) begin
        opcfg <= pwdata[OPC_W-1:0];
      end
      if (paddr == OFF_SETSEL) begin
        setsel <= pwdata[SETSEL_W-1:0];
      end
    end
  end

  // Unknown arrangement codes behave as medium
  always_comb begin
    case (ctrl[CTRL_MODE_LSB+:2])
      2'h0:    mode = DSPM_SMALL;
      2'h2:    mode = DSPM_LARGE;
      default: mode = DSPM_MEDIUM;
    endcase
  end

  logic sign_a_eff;
  logic sign_b_eff;
  logic [31:0] next_prdata;

  always_comb begin
    next_prdata = '0;
    case (paddr)
      OFF_CTRL:   next_prdata[CTRL_W-1:0]   = ctrl;
      OFF_OPCFG:  next_prdata[OPC_W-1:0]    = opcfg;
      OFF_SETSEL: next_prdata[SETSEL_W-1:0] = setsel;
      OFF_STATUS: begin
        next_prdata[1:0]         = mode;
        next_prdata[STAT_SA]     = sign_a_eff;
        next_prdata[STAT_SB]     = sign_b_eff;
        next_prdata[STAT_RSIGN]  = product_signed;
      end
      default:    next_prdata = '0;
    endcase
  end

  // Read data is captured in the setup cycle, so access completes with no wait
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (rd_setup) begin
      prdata  <= pwrite ? 32'h00000000 : next_prdata;
      pslverr <= ~mapped;
    end
  end

  // ----------------------------------------------------------------
  // Control set selection
  // ----------------------------------------------------------------
  logic [SLICES-1:0] en_a, en_b, clr_a, clr_b;
  logic [SLICES-1:0] reg_a_on, reg_b_on, sh_a, sh_b;
  logic              ctl_en, ctl_clr;

  always_comb begin
    for (int s = 0; s < SLICES; s++) begin
      en_a[s]  = ena_set[setsel[SET_STRIDE*s+:2]];
      clr_a[s] = aclr_set[setsel[SET_STRIDE*s+:2]];
      en_b[s]  = ena_set[setsel[SET_STRIDE*s+SET_B_OFS+:2]];
      clr_b[s] = aclr_set[setsel[SET_STRIDE*s+SET_B_OFS+:2]];
    end
  end

  assign ctl_en   = ena_set[ctrl[CTRL_SET_LSB+:2]];
  assign ctl_clr  = aclr_set[ctrl[CTRL_SET_LSB+:2]];
  assign reg_a_on = opcfg[OPC_REGA_LSB+:SLICES];
  assign reg_b_on = opcfg[OPC_REGB_LSB+:SLICES];
  // Large arrangement ignores shift selection: chains live outside the block
  assign sh_a     = (mode == DSPM_LARGE) ? '0 : opcfg[OPC_SHA_LSB+:SLICES];
  assign sh_b     = (mode == DSPM_LARGE) ? '0 : opcfg[OPC_SHB_LSB+:SLICES];

  // ----------------------------------------------------------------
  // Operand registers and shift chain
  // ----------------------------------------------------------------
  logic [OPBUS_W-1:0] reg_a, reg_b;
  logic [OPBUS_W-1:0] eff_a, eff_b;
  logic [OPBUS_W-1:0] shsrc_a, shsrc_b;
  logic [OPBUS_W-1:0] op_a, op_b;

  // Clear masks the stored value at once; the flop itself zeroes next edge
  always_comb begin
    for (int s = 0; s < SLICES; s++) begin
      eff_a[s*MED_W+:MED_W] = clr_a[s] ? '0 : reg_a[s*MED_W+:MED_W];
      eff_b[s*MED_W+:MED_W] = clr_b[s] ? '0 : reg_b[s*MED_W+:MED_W];
      op_a[s*MED_W+:MED_W]  = reg_a_on[s] ? eff_a[s*MED_W+:MED_W]
                                          : data_a[s*MED_W+:MED_W];
      op_b[s*MED_W+:MED_W]  = reg_b_on[s] ? eff_b[s*MED_W+:MED_W]
                                          : data_b[s*MED_W+:MED_W];
    end
  end

  // Small arrangement shifts in 9-bit units, medium in 18-bit units
  assign shsrc_a = (mode == DSPM_SMALL)
                 ? {eff_a[OPBUS_W-SMALL_W-1:0], chain_in_operand_a[SMALL_W-1:0]}
                 : {eff_a[OPBUS_W-MED_W-1:0], chain_in_operand_a};
  assign shsrc_b = (mode == DSPM_SMALL)
                 ? {eff_b[OPBUS_W-SMALL_W-1:0], chain_in_operand_b[SMALL_W-1:0]}
                 : {eff_b[OPBUS_W-MED_W-1:0], chain_in_operand_b};

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reg_a <= '0;
    end else begin
      for (int s = 0; s < SLICES; s++) begin
        if (clr_a[s]) begin
          reg_a[s*MED_W+:MED_W] <= '0;
        end else if (en_a[s]) begin
          reg_a[s*MED_W+:MED_W] <= sh_a[s] ? shsrc_a[s*MED_W+:MED_W]
                                           : data_a[s*MED_W+:MED_W];
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reg_b <= '0;
    end else begin
      for (int s = 0; s < SLICES; s++) begin
        if (clr_b[s]) begin
          reg_b[s*MED_W+:MED_W] <= '0;
        end else if (en_b[s]) begin
          reg_b[s*MED_W+:MED_W] <= sh_b[s] ? shsrc_b[s*MED_W+:MED_W]
                                           : data_b[s*MED_W+:MED_W];
        end
      end
    end
  end

  // A slice in parallel load ends the chain; the last slice drives the next block
  always_comb begin
    chain_out_operand_a = '0;
    chain_out_operand_b = '0;
    case (mode)
      DSPM_SMALL: begin
        chain_out_operand_a[SMALL_W-1:0] = eff_a[OPBUS_W-1-:SMALL_W];
        chain_out_operand_b[SMALL_W-1:0] = eff_b[OPBUS_W-1-:SMALL_W];
      end
      DSPM_MEDIUM: begin
        chain_out_operand_a = eff_a[OPBUS_W-1-:MED_W];
        chain_out_operand_b = eff_b[OPBUS_W-1-:MED_W];
      end
      default: begin
        chain_out_operand_a = '0;
        chain_out_operand_b = '0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sign control
  // ----------------------------------------------------------------
  logic sign_a_q, sign_b_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sign_a_q <= 1'b0;
      sign_b_q <= 1'b0;
    end else if (ctl_clr) begin
      sign_a_q <= 1'b0;
      sign_b_q <= 1'b0;
    end else if (ctl_en) begin
      sign_a_q <= sign_a;
      sign_b_q <= sign_b;
    end
  end

  assign sign_a_eff = ctrl[CTRL_SIGNREG] ? sign_a_q : sign_a;
  assign sign_b_eff = ctrl[CTRL_SIGNREG] ? sign_b_q : sign_b;

  // ----------------------------------------------------------------
  // Multipliers
  // ----------------------------------------------------------------
  logic [PROD_W-1:0] prod_comb;
  logic              rsign_comb;

  // Every operand gets a spare sign bit, so all listed sign pairings fit
  always_comb begin
    logic [LARGE_P_W-1:0] mul_full;
    mul_full  = '0;
    prod_comb = '0;
    case (mode)
      DSPM_SMALL: begin
        for (int u = 0; u < UNITS; u++) begin
          mul_full = dspm_mul(
            dspm_ext(LARGE_W'(op_a[u*SMALL_W+:SMALL_W]), SMALL_W, sign_a_eff),
            dspm_ext(LARGE_W'(op_b[u*SMALL_W+:SMALL_W]), SMALL_W, sign_b_eff));
          prod_comb[u*2*SMALL_W+:2*SMALL_W] = mul_full[2*SMALL_W-1:0];
        end
      end
      DSPM_LARGE: begin
        prod_comb[LARGE_P_W-1:0] = dspm_mul(
          dspm_ext(op_a[LARGE_W-1:0], LARGE_W, sign_a_eff),
          dspm_ext(op_b[LARGE_W-1:0], LARGE_W, sign_b_eff));
      end
      default: begin
        for (int s = 0; s < SLICES; s++) begin
          mul_full = dspm_mul(
            dspm_ext(LARGE_W'(op_a[s*MED_W+:MED_W]), MED_W, sign_a_eff),
            dspm_ext(LARGE_W'(op_b[s*MED_W+:MED_W]), MED_W, sign_b_eff));
          prod_comb[s*2*MED_W+:2*MED_W] = mul_full[2*MED_W-1:0];
        end
      end
    endcase
  end

  assign rsign_comb = sign_a_eff | sign_b_eff;

  // ----------------------------------------------------------------
  // Pipeline register
  // ----------------------------------------------------------------
  logic [PROD_W-1:0] prod_q;
  logic              rsign_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prod_q  <= '0;
      rsign_q <= 1'b0;
    end else if (ctl_clr) begin
      prod_q  <= '0;
      rsign_q <= 1'b0;
    end else if (ctl_en) begin
      prod_q  <= prod_comb;
      rsign_q <= rsign_comb;
    end
  end

  // Straight out to the downstream adder stage, no fabric in between
  assign product        = ctrl[CTRL_PIPE] ? prod_q : prod_comb;
  assign product_signed = ctrl[CTRL_PIPE] ? rsign_q : rsign_comb;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_clear_chain;
    @(posedge clock) disable iff (!rstn)
    (mode == DSPM_MEDIUM && clr_a[SLICES-1]) |-> chain_out_operand_a == '0;
  endproperty
  a_clear_chain: assert property (p_clear_chain)
    else $error("chain output not zero under clear");

  property p_par_load;
    @(posedge clock) disable iff (!rstn)
    (en_a[0] && !clr_a[0] && !sh_a[0]) ##1 !clr_a[0]
      |-> eff_a[MED_W-1:0] == $past(data_a[MED_W-1:0]);
  endproperty
  a_par_load: assert property (p_par_load)
    else $error("parallel load lost operand");

  property p_shift_step;
    @(posedge clock) disable iff (!rstn)
    (mode == DSPM_MEDIUM && sh_b[1] && en_b[1] && !clr_b[1] && !clr_b[0])
      ##1 (!clr_b[1] && mode == DSPM_MEDIUM)
      |-> reg_b[2*MED_W-1:MED_W] == $past(reg_b[MED_W-1:0]);
  endproperty
  a_shift_step: assert property (p_shift_step)
    else $error("chain did not advance one slice");

  property p_large_no_chain;
    @(posedge clock) disable iff (!rstn)
    (mode == DSPM_LARGE) |-> (chain_out_operand_a == '0 && chain_out_operand_b == '0);
  endproperty
  a_large_no_chain: assert property (p_large_no_chain)
    else $error("chain active in large arrangement");

  property p_rsign;
    @(posedge clock) disable iff (!rstn)
    (!ctrl[CTRL_PIPE] && !ctrl[CTRL_SIGNREG]) |-> product_signed == (sign_a | sign_b);
  endproperty
  a_rsign: assert property (p_rsign)
    else $error("product sign wrong");

  property p_pipe_delay;
    @(posedge clock) disable iff (!rstn)
    (ctrl[CTRL_PIPE] && ctl_en && !ctl_clr) ##1 ctrl[CTRL_PIPE] |-> product == $past(prod_comb);
  endproperty
  a_pipe_delay: assert property (p_pipe_delay)
    else $error("pipeline register not one cycle");

  property p_bypass_mul;
    @(posedge clock) disable iff (!rstn)
    (mode == DSPM_MEDIUM && reg_a_on[0] == 1'b0 && reg_b_on[0] == 1'b0 &&
     !ctrl[CTRL_PIPE] && !sign_a_eff && !sign_b_eff)
      |-> product[2*MED_W-1:0] == data_a[MED_W-1:0] * data_b[MED_W-1:0];
  endproperty
  a_bypass_mul: assert property (p_bypass_mul)
    else $error("bypassed product wrong");

  property p_sign_reg;
    @(posedge clock) disable iff (!rstn)
    (ctrl[CTRL_SIGNREG] && ctl_en && !ctl_clr) ##1 ctrl[CTRL_SIGNREG]
      |-> sign_a_eff == $past(sign_a);
  endproperty
  a_sign_reg: assert property (p_sign_reg)
    else $error("registered sign not one cycle");

endmodule : dspm_input_stage

// file: src/dspm_pkg.sv
// Constants, register map and mode encodings for the multiplier input stage
package dspm_pkg;

  // ----------------------------------------------------------------
  // Datapath geometry
  // ----------------------------------------------------------------
  localparam int SLICES     = 4;
  localparam int SMALL_W    = 9;
  localparam int MED_W      = 18;
  localparam int LARGE_W    = 36;
  localparam int EXT_W      = 37;
  localparam int UNITS      = 8;
  localparam int OPBUS_W    = 72;
  localparam int PROD_W     = 144;
  localparam int LARGE_P_W  = 72;

  // ----------------------------------------------------------------
  // Arrangements
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DSPM_SMALL  = 2'b00,
    DSPM_MEDIUM = 2'b01,
    DSPM_LARGE  = 2'b10
  } dspm_mode_e;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_CTRL   = 12'h000;
  localparam logic [11:0] OFF_OPCFG  = 12'h004;
  localparam logic [11:0] OFF_SETSEL = 12'h008;
  localparam logic [11:0] OFF_STATUS = 12'h00C;

  // Control fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_PIPE     = 2;
  localparam int CTRL_SIGNREG  = 3;
  localparam int CTRL_SET_LSB  = 4;
  localparam int CTRL_W        = 6;

  // Operand configuration fields
  localparam int OPC_REGA_LSB  = 0;
  localparam int OPC_REGB_LSB  = 4;
  localparam int OPC_SHA_LSB   = 8;
  localparam int OPC_SHB_LSB   = 12;
  localparam int OPC_W         = 16;

  // Set select: slice s uses bits [4s+1:4s] for A, [4s+3:4s+2] for B
  localparam int SETSEL_W      = 16;
  localparam int SET_STRIDE    = 4;
  localparam int SET_B_OFS     = 2;

  // Status fields
  localparam int STAT_SA       = 2;
  localparam int STAT_SB       = 3;
  localparam int STAT_RSIGN    = 4;

  // Reset values
  localparam logic [CTRL_W-1:0]   CTRL_RST   = 6'h01;
  localparam logic [OPC_W-1:0]    OPC_RST    = 16'h0000;
  localparam logic [SETSEL_W-1:0] SETSEL_RST = 16'h0000;

endpackage : dspm_pkg

// file: bench/dspm_fabric_model.sv
// Fabric-side user logic that feeds operands and the shift chain
`timescale 1ns/100ps
module dspm_fabric_model
  import dspm_pkg::*;
(
  input  wire logic               clock,
  output logic [OPBUS_W-1:0]      data_a,
  output logic [OPBUS_W-1:0]      data_b,
  output logic                    sign_a,
  output logic                    sign_b,
  output logic [MED_W-1:0]        chain_in_operand_a,
  output logic [MED_W-1:0]        chain_in_operand_b
);
  initial begin
    data_a = '0;
    data_b = '0;
    sign_a = 1'b0;
    sign_b = 1'b0;
    chain_in_operand_a = '0;
    chain_in_operand_b = '0;
  end

  // ----------------------------------------------------------------
  // Parallel operands, replicated over every unit of the arrangement
  // ----------------------------------------------------------------
  task automatic put(input dspm_mode_e m, input logic [35:0] a, input logic [35:0] b,
                     input logic sa, input logic sb);
    @(posedge clock);
    sign_a <= sa;
    sign_b <= sb;
    // Upper half is unused in the large arrangement, so drive noise there
    data_a <= (m == DSPM_SMALL) ? {8{a[8:0]}} : (m == DSPM_MEDIUM) ? {4{a[17:0]}} : {~a, a};
    data_b <= (m == DSPM_SMALL) ? {8{b[8:0]}} : (m == DSPM_MEDIUM) ? {4{b[17:0]}} : {~b, b};
  endtask : put

  // Samples enter the A chain and their inverse the B chain; only used outside the large arrangement
  task automatic chain(input logic [MED_W-1:0] v);
    @(posedge clock);
    chain_in_operand_a <= v;
    chain_in_operand_b <= ~v;
  endtask : chain
endmodule : dspm_fabric_model

// file: bench/tb_top.sv
// Self-checking testbench for the multiplier input stage
`timescale 1ns/100ps
module tb_top
  import dspm_pkg::*;
;
  typedef struct {
    logic [35:0] a;
    logic [35:0] b;
    logic        sa;
    logic        sb;
  } dspm_row_s;

  logic                 clock = 1'b0;
  logic                 rstn;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic [11:0]          paddr;
  logic [31:0]          pwdata;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic [OPBUS_W-1:0]   data_a;
  logic [OPBUS_W-1:0]   data_b;
  logic                 sign_a;
  logic                 sign_b;
  logic [3:0]           ena_set;
  logic [3:0]           aclr_set;
  logic [MED_W-1:0]     cin_a;
  logic [MED_W-1:0]     cin_b;
  logic [MED_W-1:0]     chain_out_operand_a;
  logic [MED_W-1:0]     chain_out_operand_b;
  logic [PROD_W-1:0]    product;
  logic                 product_signed;
  int                   n_errors = 0;
  int                   tests_run = 0;
  int                   w;
  logic [35:0]          ma;
  logic [35:0]          mb;
  logic [71:0]          e;
  dspm_row_s            rows [4] = '{
    '{36'hF_FFFF_FFFF, 36'hF_FFFF_FFFF, 1'b0, 1'b0},
    '{36'hF_FFFF_FFFF, 36'hF_FFFF_FFFF, 1'b1, 1'b1},
    '{36'h9_8765_4321, 36'hF_EDCB_A987, 1'b1, 1'b0},
    '{36'h9_8765_4321, 36'hF_EDCB_A987, 1'b0, 1'b1}};

  always #2 clock = ~clock;

  dspm_input_stage dut_u (
    .clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .data_a(data_a), .data_b(data_b), .sign_a(sign_a), .sign_b(sign_b),
    .ena_set(ena_set), .aclr_set(aclr_set),
    .chain_in_operand_a(cin_a), .chain_in_operand_b(cin_b),
    .chain_out_operand_a(chain_out_operand_a), .chain_out_operand_b(chain_out_operand_b),
    .product(product), .product_signed(product_signed));

  dspm_fabric_model fab_u (
    .clock(clock), .data_a(data_a), .data_b(data_b), .sign_a(sign_a), .sign_b(sign_b),
    .chain_in_operand_a(cin_a), .chain_in_operand_b(cin_b));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [71:0] seen, input logic [71:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Two's complement taken modulo a wide word, then cut to full precision
  function automatic logic [71:0] ref_mul(input logic [35:0] a, input logic [35:0] b,
                                          input int wd, input logic sa, input logic sb);
    logic [73:0] ea;
    logic [73:0] eb;
    logic [73:0] p;
    ea = {38'h0, a};
    eb = {38'h0, b};
    if (sa && a[wd-1]) ea = ea - (74'h1 << wd);
    if (sb && b[wd-1]) eb = eb - (74'h1 << wd);
    p = (ea * eb) & ((74'h1 << (2 * wd)) - 74'h1);
    return p[71:0];
  endfunction : ref_mul

  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk("pready", pready, 72'h1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] ad, input logic [31:0] wd);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, ad, wd, rd, er);
  endtask : wr

  task automatic rchk(input string nm, input logic [11:0] ad, input logic [31:0] x,
                      input logic xe);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, ad, 32'h0, rd, er);
    chk(nm, rd, x);
    chk({nm, "_err"}, er, xe);
  endtask : rchk

  task automatic give_verdict();
    $display("TB: errors %0d, checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  initial begin
    #80000;
    n_errors++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    ena_set = '0;
    aclr_set = '0;
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    rchk("ctrl_rst", OFF_CTRL, 32'h1, 1'b0);
    rchk("opcfg_rst", OFF_OPCFG, 32'h0, 1'b0);
    rchk("setsel_rst", OFF_SETSEL, 32'h0, 1'b0);
    wr(OFF_STATUS, 32'h1F);
    rchk("status_ro", OFF_STATUS, 32'h1, 1'b0);
    rchk("unmapped", 12'h010, 32'h0, 1'b1);
    // Every arrangement, every sign pairing, bypassed registers
    for (int m = 0; m < 3; m++) begin
      wr(OFF_CTRL, 32'(m));
      w = (m == 0) ? SMALL_W : (m == 1) ? MED_W : LARGE_W;
      for (int i = 0; i < 4; i++) begin
        ma = rows[i].a & ((36'h1 << w) - 36'h1);
        mb = rows[i].b & ((36'h1 << w) - 36'h1);
        fab_u.put(dspm_mode_e'(m), ma, mb, rows[i].sa, rows[i].sb);
        @(negedge clock);
        e = ref_mul(ma, mb, w, rows[i].sa, rows[i].sb);
        chk("prod_first", product[71:0] & ((72'h1 << (2 * w)) - 72'h1), e);
        if (m == 2) chk("prod_upper", product[143:72], 72'h0);
        else chk("prod_last", 72'(product >> (PROD_W - 2 * w)), e);
        chk("prod_sign", product_signed, rows[i].sa | rows[i].sb);
      end
    end
    // Registered operands on separate control sets, then a clear
    wr(OFF_CTRL, 32'h1);
    wr(OFF_OPCFG, 32'h0011);
    wr(OFF_SETSEL, 32'h0001);
    fab_u.put(DSPM_MEDIUM, 36'h5, 36'h3, 1'b0, 1'b0);
    @(negedge clock);
    chk("reg_hold", product[35:0], 72'h0);
    @(posedge clock);
    ena_set <= 4'h1;
    @(posedge clock);
    @(negedge clock);
    chk("reg_b_only", product[35:0], 72'h0);
    @(posedge clock);
    ena_set <= 4'h3;
    @(posedge clock);
    @(negedge clock);
    chk("reg_both", product[35:0], 72'hF);
    @(posedge clock);
    aclr_set <= 4'h2;
    @(negedge clock);
    chk("clear_now", product[35:0], 72'h0);
    @(posedge clock);
    aclr_set <= 4'h0;
    ena_set <= 4'h1;
    // Pipeline register after the multiplier
    wr(OFF_OPCFG, 32'h0);
    wr(OFF_SETSEL, 32'h0);
    wr(OFF_CTRL, 32'h5);
    fab_u.put(DSPM_MEDIUM, 36'h2, 36'h2, 1'b0, 1'b0);
    repeat (2) @(posedge clock);
    fab_u.put(DSPM_MEDIUM, 36'h7, 36'h9, 1'b0, 1'b0);
    @(negedge clock);
    chk("pipe_old", product[35:0], 72'h4);
    @(negedge clock);
    chk("pipe_new", product[35:0], 72'h3F);
    // A shifts along the chain while B loads in parallel
    wr(OFF_CTRL, 32'h1);
    wr(OFF_OPCFG, 32'h0F0F);
    fab_u.put(DSPM_MEDIUM, 36'h0, 36'h1, 1'b0, 1'b0);
    for (int v = 1; v <= 4; v++) fab_u.chain(18'(v));
    @(posedge clock);
    @(negedge clock);
    chk("chain_out", chain_out_operand_a, 72'h1);
    chk("shift_first", product[35:0], 72'h4);
    chk("shift_last", product[143:108], 72'h1);
    chk("chain_out_b", chain_out_operand_b, 72'h1);
    // Registered sign lags the operand by one enabled edge
    wr(OFF_CTRL, 32'h9);
    fab_u.put(DSPM_MEDIUM, 36'h1, 36'h1, 1'b1, 1'b0);
    @(negedge clock);
    chk("sign_late", product_signed, 72'h0);
    @(negedge clock);
    chk("sign_reg", product_signed, 72'h1);
    wr(OFF_CTRL, 32'h2);
    @(negedge clock);
    chk("chain_large", chain_out_operand_a, 72'h0);
    give_verdict();
  end
endmodule : tb_top
